//--- test/wdc_top_test.sv
// Self-checking bench for the watchdog down-counter
`timescale 1ns/10ps
`include "wdc_consts.svh"
module wdc_top_test;
	localparam int PL = 64;
	localparam int RC = 13;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_wake;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid, wdg_reset_n;
	logic [1:0] bresp, rresp, tb;
	logic [33:0] bq_exp[$], bq_msk[$];
	int pq[$];
	int bad_count = 0;
	int samples_checked = 0;
	int plen = 0;
	int n, k, lsb, lo;
	integer seed = 32'h32342e60;

	// Short prescaler keeps every timeout within about 4096 cycles
	wdc_top #(.PRESC_LEN(PL), .RST_CYC(RC)) i_wdc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ext_wake(ext_wake), .wdg_reset_n(wdg_reset_n));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	// Watches both answers and reset pulses; notes are taken oldest first
	always @(posedge aclk) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			if (bq_exp.size() == 0)
				chk("unexpected answer", 34'h0, 34'h1);
			else
				chk("bus answer", bq_exp.pop_front(), (bvalid ? {bresp, 32'h0} : {rresp, rdata}) & bq_msk.pop_front());
		end
		if (!aresetn)
			plen = 0;
		else if (!wdg_reset_n)
			plen = plen + 1;
		else if (plen != 0) begin
			if (pq.size() == 0)
				chk("unexpected pulse", 34'h0, 34'(plen));
			else
				chk("pulse length", 34'(pq.pop_front()), 34'(plen));
			plen = 0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic rst(input int c);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (c) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : rst

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		int i;
		@(posedge aclk);
		bq_exp.push_back({r, 32'h0});
		bq_msk.push_back({2'h3, 32'h0});
		awaddr <= a;
		wdata <= {24'($random(seed)), d};
		wstrb <= {3'($random(seed)), 1'b1};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (i == 50) begin
			chk("write wait", 34'h0, 34'h1);
			stop_test();
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input logic [1:0] r);
		int i;
		@(posedge aclk);
		bq_exp.push_back({r, 24'h0, e & m});
		bq_msk.push_back({2'h3, 24'hFFFFFF, m});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (i == 50) begin
			chk("read wait", 34'h0, 34'h1);
			stop_test();
		end
	endtask : rd

	// A pulse must start within lo..hi cycles; its length is judged by the watcher
	task automatic pulse(input int lo, input int hi);
		int i;
		pq.push_back(RC);
		for (i = 0; i <= hi; i++) begin
			@(posedge aclk);
			if (!wdg_reset_n) break;
		end
		chk("pulse start", 34'h1, 34'(i >= lo && i <= hi));
		for (i = 0; i < 40 && !wdg_reset_n; i++) @(posedge aclk);
		repeat (2) @(posedge aclk);
	endtask : pulse

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, ext_wake} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		rst(12);
		rd(`WDC_ADDR_CTRL, 8'h7F, 8'hFF, `WDC_RESP_OKAY);
		rd(8'h00, 8'h00, 8'hFF, `WDC_RESP_SLVERR);
		wr(8'h40, 8'hFF, `WDC_RESP_SLVERR);
		// Inactive counter crosses 40h to 3Fh with no pulse
		repeat (64 * PL + 4) @(posedge aclk);
		rd(`WDC_ADDR_CTRL, 8'h3F, 8'hFF, `WDC_RESP_OKAY);
		rst(2);
		wr(`WDC_ADDR_CTRL, 8'hC5, `WDC_RESP_OKAY);
		wr(`WDC_ADDR_CTRL, 8'h45, `WDC_RESP_OKAY);
		rd(`WDC_ADDR_CTRL, 8'h80, 8'h80, `WDC_RESP_OKAY);
		wr(`WDC_ADDR_CTRL, 8'hBF, `WDC_RESP_OKAY);
		pulse(0, 4);
		rst(2);
		repeat (6) begin
			wr(`WDC_ADDR_CTRL, 8'hC1, `WDC_RESP_OKAY);
			repeat (30) @(posedge aclk);
		end
		// Every timebase with a random step count
		for (k = 0; k < 4; k++) begin
			rst(2);
			tb = 2'(k);
			n = $random(seed) & 3;
			case (tb)
				2'h0: lsb = `WDC_LSB_TB0;
				2'h1: lsb = `WDC_LSB_TB1;
				2'h2: lsb = `WDC_LSB_TB2;
				default: lsb = `WDC_LSB_TB3;
			endcase
			lo = (n == 0 ? (lsb + 128) * 64 * PL / 16384 : 64 * n) - 2;
			wr(`WDC_ADDR_CFG, {2'b00, tb, 4'h0}, `WDC_RESP_OKAY);
			wr(`WDC_ADDR_CTRL, 8'hC0 | 8'(n), `WDC_RESP_OKAY);
			pulse(lo, 64 * n + 66);
		end
		rst(2);
		wr(`WDC_ADDR_CFG, 8'h01, `WDC_RESP_OKAY);
		wr(`WDC_ADDR_CTRL, 8'h40, `WDC_RESP_OKAY);
		rd(`WDC_ADDR_STAT, 8'h01, 8'h01, `WDC_RESP_OKAY);
		pulse(0, 66);
		rd(`WDC_ADDR_CTRL, 8'h00, 8'h80, `WDC_RESP_OKAY);
		rst(2);
		wr(`WDC_ADDR_CFG, 8'h02, `WDC_RESP_OKAY);
		wr(`WDC_ADDR_CTRL, 8'hFF, `WDC_RESP_OKAY);
		wr(`WDC_ADDR_HALT, 8'h01, `WDC_RESP_OKAY);
		pulse(0, 4);
		// Without the halt option the device stops instead, then wakes late
		rst(2);
		wr(`WDC_ADDR_CTRL, 8'hFF, `WDC_RESP_OKAY);
		wr(`WDC_ADDR_HALT, 8'h01, `WDC_RESP_OKAY);
		rd(`WDC_ADDR_STAT, 8'h02, 8'h06, `WDC_RESP_OKAY);
		@(posedge aclk) ext_wake <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(`WDC_ADDR_STAT, 8'h04, 8'h06, `WDC_RESP_OKAY);
		repeat (260) @(posedge aclk);
		rd(`WDC_ADDR_STAT, 8'h00, 8'h06, `WDC_RESP_OKAY);
		@(posedge aclk) ext_wake <= 1'b0;
		repeat (4) @(posedge aclk);
		// Active halt: no reset even with the halt option, and wake resumes at once
		rst(2);
		wr(`WDC_ADDR_CFG, 8'h06, `WDC_RESP_OKAY);
		wr(`WDC_ADDR_CTRL, 8'hFF, `WDC_RESP_OKAY);
		wr(`WDC_ADDR_HALT, 8'h01, `WDC_RESP_OKAY);
		rd(`WDC_ADDR_STAT, 8'h02, 8'h06, `WDC_RESP_OKAY);
		@(posedge aclk) ext_wake <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(`WDC_ADDR_STAT, 8'h00, 8'h06, `WDC_RESP_OKAY);
		@(posedge aclk) ext_wake <= 1'b0;
		repeat (4) @(posedge aclk);
		stop_test();
	end

	initial begin
		#4000000;
		chk("run time", 34'h0, 34'h1);
		stop_test();
	end
endmodule : wdc_top_test

//--- verilog/wdc_consts.svh
// Offsets, fields, reset values and timing counts of the watchdog down-counter
`ifndef WDC_CONSTS_SVH
`define WDC_CONSTS_SVH
`define WDC_ADDR_CTRL 8'h24
`define WDC_ADDR_CFG 8'h28
`define WDC_ADDR_HALT 8'h2C
`define WDC_ADDR_STAT 8'h30
`define WDC_ACT_RESET 1'b0
`define WDC_CNT_RESET 7'h7F
`define WDC_CFG_RESET 6'h00
`define WDC_ACT_BIT 7
`define WDC_TOP_BIT 6
`define WDC_CFG_HW 0
`define WDC_CFG_HALTRST 1
`define WDC_CFG_OIE 2
`define WDC_CFG_WLONG 3
`define WDC_CFG_TB 5:4
`define WDC_CFG_MSB 5
`define WDC_STAT_ACT 0
`define WDC_STAT_HALT 1
`define WDC_STAT_WAKE 2
`define WDC_STAT_BUSY 3
`define WDC_ROLL_CNT 7'h40
`define WDC_PRESC_LEN 16384
`define WDC_MIN0_ADD 128
`define WDC_MIN0_MUL 64
`define WDC_LSB_TB0 59
`define WDC_LSB_TB1 53
`define WDC_LSB_TB2 35
`define WDC_LSB_TB3 54
`define WDC_CLK_MHZ 25
`define WDC_RST_NS 500
`define WDC_RST_CYC ((`WDC_RST_NS * `WDC_CLK_MHZ + 999) / 1000)
`define WDC_WAKE_SHORT 256
`define WDC_WAKE_LONG 4096
`define WDC_RESP_OKAY 2'b00
`define WDC_RESP_SLVERR 2'b10
`endif

//--- verilog/wdc_pkg.sv
// Types of the watchdog down-counter
package wdc_pkg;
	typedef enum logic [2:0] {
		HM_RUN = 3'b001,
		HM_HALT = 3'b010,
		HM_WAKE = 3'b100
	} wdc_halt_t;
	typedef struct packed {
		logic [13:0] cnt;
		logic tc;
	} wdc_presc_t;
	typedef struct packed {
		logic [4:0] cnt;
		logic rst_n;
	} wdc_pulse_t;
	typedef struct packed {
		logic act;
		logic [6:0] cnt;
		wdc_halt_t hm;
		logic one_more;
		logic [11:0] wake_cnt;
		logic [13:0] guard;
		logic defer;
		logic [5:0] cfg;
		logic [2:0] wk;
		logic wk_lvl;
		logic fire;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [7:0] wbyte;
		logic wstb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} wdc_state_t;
endpackage : wdc_pkg

//--- verilog/wdc_prescaler.sv
// Free-running prescaler that paces the watchdog count
`timescale 1ns/10ps
`include "wdc_consts.svh"
module wdc_prescaler #(
	parameter int LEN = `WDC_PRESC_LEN
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic tc
);
	import wdc_pkg::*;
	wdc_presc_t s;
	wdc_presc_t next_s;
	logic [14:0] gap;

	if (LEN < `WDC_MIN0_MUL || LEN > `WDC_PRESC_LEN || (LEN & (LEN - 1)) != 0) begin : g_len_check
		$error("LEN must be a power of two from 64 to 16384");
	end

	// Never cleared by software, so the first step after a refresh varies
	always_comb begin
		next_s = s;
		next_s.tc = 1'b0;
		if (s.cnt == 14'(LEN - 1)) begin
			next_s.cnt = 14'h0000;
			next_s.tc = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 14'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tc = s.tc;

	// Cycles since the last terminal count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap <= 15'h0000;
		end else if (s.tc) begin
			gap <= 15'h0001;
		end else begin
			gap <= gap + 15'h0001;
		end
	end

	a_presc_period: assert property (@(posedge aclk) disable iff (!aresetn) s.tc |-> gap == 15'(LEN))
		else $error("prescaler period wrong");
endmodule : wdc_prescaler

//--- verilog/wdc_reset_pulse.sv
// Stretches a reset request into a fixed low pulse
`timescale 1ns/10ps
`include "wdc_consts.svh"
module wdc_reset_pulse #(
	parameter int CYC = `WDC_RST_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic fire,
	output logic rst_n
);
	import wdc_pkg::*;
	wdc_pulse_t s;
	wdc_pulse_t next_s;

	if (CYC < 2 || CYC > 31) begin : g_cyc_check
		$error("CYC must lie from 2 to 31");
	end

	// Requests during a pulse are dropped; the pulse already resets
	always_comb begin
		next_s = s;
		if (s.cnt == 5'h00) begin
			if (fire) begin
				next_s.cnt = 5'(CYC);
				next_s.rst_n = 1'b0;
			end
		end else if (s.cnt == 5'h01) begin
			next_s.cnt = 5'h00;
			next_s.rst_n = 1'b1;
		end else begin
			next_s.cnt = s.cnt - 5'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s.cnt <= 5'h00;
			s.rst_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign rst_n = s.rst_n;
endmodule : wdc_reset_pulse

//--- verilog/wdc_top.sv
// Watchdog down-counter with AXI4-Lite register access
`timescale 1ns/10ps
`include "wdc_consts.svh"

// Function
// - Count steps down once per 16384 oscillator cycles through a prescaler.
// - Active watchdog rolling 40h to 3Fh outside halt fires a reset pulse of about 500ns.
// - Counter runs whether active or not; a rollover while inactive gives no reset.
// - Six low count bits give the timeout in 64 prescaler-period steps.
// - Watchdog starts inactive after any reset.
// - Activation is sticky; writing zero does nothing, only reset clears.
// - Write with activation set and top count bit clear resets at once.
// - Halt while active resets when the halt option asks for it, unless active halt is set.
// - Control writes leave the prescaler running, so timeout varies.
// - First step after a control write waits the timebase-dependent minimum interval.
// - A hardware watchdog option replaces software activation.
// - Hardware option keeps the watchdog active and ignores activation bit.
// - Wake from halt resumes counting after 256 or 4096 clocks, or at once with active halt set.
// - Control byte resets to 7Fh, inactive with all count bits set.
module wdc_top #(
	parameter int PRESC_LEN = `WDC_PRESC_LEN,
	parameter int RST_CYC = `WDC_RST_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ext_wake,
	output logic wdg_reset_n
);
	import wdc_pkg::*;

	wdc_state_t s;
	wdc_state_t next_s;
	logic presc_tc;
	logic eff_act;
	logic guard_ok;
	logic tick;
	logic run;
	logic wake_go;
	logic do_wr;
	logic ctrl_wr;
	logic halt_wr;
	logic wr_act;
	logic sw_kill;
	logic rd_go;
	logic [13:0] min0;

	////////////////////////////////////////
	// Decoding

	function automatic logic wdc_mapped(input logic [7:0] a);
		return a == `WDC_ADDR_CTRL || a == `WDC_ADDR_CFG || a == `WDC_ADDR_HALT || a == `WDC_ADDR_STAT;
	endfunction : wdc_mapped

	// Least wait after a refresh, scaled with a shortened prescaler
	function automatic logic [13:0] wdc_min0(input logic [1:0] tb);
		int lsb;
		case (tb)
			2'h0: lsb = `WDC_LSB_TB0;
			2'h1: lsb = `WDC_LSB_TB1;
			2'h2: lsb = `WDC_LSB_TB2;
			default: lsb = `WDC_LSB_TB3;
		endcase
		return 14'(((lsb + `WDC_MIN0_ADD) * `WDC_MIN0_MUL * PRESC_LEN) / `WDC_PRESC_LEN);
	endfunction : wdc_min0

	////////////////////////////////////////
	// Submodules

	wdc_prescaler #(
		.LEN(PRESC_LEN)
	) i_wdc_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.tc(presc_tc)
	);

	wdc_reset_pulse #(
		.CYC(RST_CYC)
	) i_wdc_reset_pulse (
		.aclk(aclk),
		.aresetn(aresetn),
		.fire(s.fire),
		.rst_n(wdg_reset_n)
	);

	////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;
		next_s.fire = 1'b0;
		// Wake pin: three stages, a change counts once the last two agree
		next_s.wk = {s.wk[1:0], ext_wake};
		if (s.wk[2] == s.wk[1]) begin
			next_s.wk_lvl = s.wk[2];
		end
		wake_go = next_s.wk_lvl & ~s.wk_lvl;
		eff_act = s.act | s.cfg[`WDC_CFG_HW];
		min0 = wdc_min0(s.cfg[`WDC_CFG_TB]);
		guard_ok = s.guard >= min0;
		if (!guard_ok) begin
			next_s.guard = s.guard + 14'h0001;
		end
		// A prescaler step inside the least wait is held back, not lost
		tick = guard_ok & (presc_tc | s.defer);
		next_s.defer = ~guard_ok & (s.defer | presc_tc);
		run = (s.hm == HM_RUN) | ((s.hm == HM_HALT) & s.one_more);
		if (tick & run) begin
			next_s.cnt = s.cnt - 7'h01;
			next_s.one_more = 1'b0;
			if (s.cnt == `WDC_ROLL_CNT && eff_act && s.hm == HM_RUN) begin
				next_s.fire = 1'b1;
			end
		end

		// Write channels, taken in either order
		if (s.bvalid & bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.awready & awvalid) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = awaddr;
		end
		if (s.wready & wvalid) begin
			next_s.w_got = 1'b1;
			next_s.wbyte = wdata[7:0];
			next_s.wstb = wstrb[0];
		end
		do_wr = next_s.aw_got & next_s.w_got & ~s.bvalid;
		ctrl_wr = do_wr & next_s.wstb & (next_s.awaddr == `WDC_ADDR_CTRL);
		halt_wr = do_wr & next_s.wstb & (next_s.awaddr == `WDC_ADDR_HALT) & (s.hm == HM_RUN);
		wr_act = s.act | next_s.wbyte[`WDC_ACT_BIT];
		sw_kill = ctrl_wr & (wr_act | s.cfg[`WDC_CFG_HW]) & ~next_s.wbyte[`WDC_TOP_BIT];
		if (do_wr) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = wdc_mapped(next_s.awaddr) ? `WDC_RESP_OKAY : `WDC_RESP_SLVERR;
		end
		// A refresh overrides the count of a step in the same cycle, but not its rollover reset
		if (ctrl_wr) begin
			next_s.act = wr_act;
			next_s.cnt = next_s.wbyte[6:0];
			next_s.guard = 14'h0000;
			next_s.defer = 1'b0;
		end
		if (sw_kill) begin
			next_s.fire = 1'b1;
		end
		if (do_wr && next_s.wstb && next_s.awaddr == `WDC_ADDR_CFG) begin
			next_s.cfg = next_s.wbyte[`WDC_CFG_MSB:0];
		end

		// Halt and wake sequencing
		unique case (s.hm)
			HM_RUN: begin
				if (halt_wr) begin
					if (eff_act & s.cfg[`WDC_CFG_HALTRST] & ~s.cfg[`WDC_CFG_OIE]) begin
						next_s.fire = 1'b1;
					end else begin
						next_s.hm = HM_HALT;
						next_s.one_more = ~s.cfg[`WDC_CFG_OIE];
					end
				end
			end
			HM_HALT: begin
				if (wake_go) begin
					if (s.cfg[`WDC_CFG_OIE]) begin
						next_s.hm = HM_RUN;
					end else begin
						next_s.hm = HM_WAKE;
						next_s.wake_cnt = s.cfg[`WDC_CFG_WLONG] ? 12'(`WDC_WAKE_LONG - 1) : 12'(`WDC_WAKE_SHORT - 1);
					end
				end
			end
			HM_WAKE: begin
				if (s.wake_cnt == 12'h000) begin
					next_s.hm = HM_RUN;
				end else begin
					next_s.wake_cnt = s.wake_cnt - 12'h001;
				end
			end
			default: begin
				next_s.hm = HM_RUN;
			end
		endcase

		// Read channel
		rd_go = s.arready & arvalid;
		if (s.rvalid & rready) begin
			next_s.rvalid = 1'b0;
		end
		if (rd_go) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = wdc_mapped(araddr) ? `WDC_RESP_OKAY : `WDC_RESP_SLVERR;
			case (araddr)
				`WDC_ADDR_CTRL: next_s.rdata = 32'({s.act, s.cnt});
				`WDC_ADDR_CFG: next_s.rdata = 32'(s.cfg);
				`WDC_ADDR_STAT: begin
					next_s.rdata = 32'h00000000;
					next_s.rdata[`WDC_STAT_ACT] = eff_act;
					next_s.rdata[`WDC_STAT_HALT] = s.hm == HM_HALT;
					next_s.rdata[`WDC_STAT_WAKE] = s.hm == HM_WAKE;
					next_s.rdata[`WDC_STAT_BUSY] = ~wdg_reset_n;
				end
				default: next_s.rdata = 32'h00000000;
			endcase
		end
		next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
		next_s.wready = ~next_s.w_got & ~next_s.bvalid;
		next_s.arready = ~next_s.rvalid;
	end

	////////////////////////////////////////
	// State register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.act <= `WDC_ACT_RESET;
			s.cnt <= `WDC_CNT_RESET;
			s.hm <= HM_RUN;
			s.cfg <= `WDC_CFG_RESET;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;

	////////////////////////////////////////
	// Checks

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_roll;
		tick && run && s.hm == HM_RUN && s.cnt == `WDC_ROLL_CNT && !ctrl_wr;
	endsequence

	sequence s_quiet;
		wdg_reset_n && !s.fire;
	endsequence

	sequence s_pulse;
		s.fire ##1 !wdg_reset_n;
	endsequence

	sequence s_low_then_high;
		(!wdg_reset_n) [*8] ##5 !wdg_reset_n ##1 wdg_reset_n;
	endsequence

	sequence s_wake_short;
		s.hm == HM_WAKE ##256 s.hm == HM_RUN;
	endsequence

	a_reset_value: assert property ($rose(aresetn) |-> !s.act && s.cnt == `WDC_CNT_RESET)
		else $error("control byte reset value wrong");

	a_act_sticky: assert property (s.act |=> s.act)
		else $error("activation bit cleared without reset");

	a_roll_fire: assert property (s_roll ##0 eff_act ##0 s_quiet |=> s_pulse)
		else $error("rollover while active gave no reset");

	a_pulse_len: assert property ($fell(wdg_reset_n) |-> s_low_then_high)
		else $error("reset pulse length wrong");

	a_free_count: assert property (tick && run && !ctrl_wr |=> s.cnt == $past(s.cnt) - 7'h01)
		else $error("counter did not step");

	a_idle_roll: assert property (s_roll ##0 !eff_act ##0 !halt_wr |=> !s.fire)
		else $error("reset from inactive watchdog");

	a_soft_reset: assert property (sw_kill ##0 s_quiet |=> s_pulse)
		else $error("software reset not produced");

	a_halt_reset: assert property (halt_wr && eff_act && s.cfg[`WDC_CFG_HALTRST] && !s.cfg[`WDC_CFG_OIE]
		|=> s.fire && s.hm == HM_RUN)
		else $error("halt while active gave no reset");

	a_hw_force: assert property (s_roll ##0 (s.cfg[`WDC_CFG_HW] && !s.act) |=> s.fire)
		else $error("hardware option did not force activity");

	a_min_wait: assert property (presc_tc && !guard_ok && !ctrl_wr |=> s.cnt == $past(s.cnt) && s.defer)
		else $error("step taken before least wait");

	a_wake_delay: assert property (wake_go && s.hm == HM_HALT && !s.cfg[`WDC_CFG_OIE] && !s.cfg[`WDC_CFG_WLONG]
		|=> s_wake_short)
		else $error("wake delay wrong");
endmodule : wdc_top
